// *** bench/test_ehci_command_run_reset_ctrl.sv ***
/*
 * Self-checking bench for the command register control block: drives
 * command writes through the strobe/data ports and checks readback,
 * run/halt handshake, frame list sizing, fetch address and the
 * controller's own reset sequence.
 * Assumes the design package is compiled first; no other models.
 */
`timescale 1ns/1ps
`default_nettype none
module test_ehci_command_run_reset_ctrl
    import ehc_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int unsigned RST_LEN = 8;
    logic                 clk;
    logic                 resetn;
    logic                 cmd_wr;
    logic [31:0]          wdata;
    logic                 pfl;
    logic                 busy;
    logic                 err;
    logic [FRINDEX_W-1:0] frindex;
    logic [31:0]          base;
    logic [31:0]          rdata;
    logic                 halted;
    logic                 run;
    logic                 fetch_en;
    logic [31:0]          faddr;
    logic [ENTRIES_W-1:0] entries;
    logic                 ctl_rst;
    logic                 port_comp;
    logic [10:0]          ent_tab [3] = '{11'h400, 11'h200, 11'h100};
    int                   n_errors;
    int                   comparisons;
    int                   k;

    ehc_usb_command_ctrl #(.SOFT_RESET_LEN(RST_LEN)) dut_u (
        .CLK_IN         (clk),
        .RESETN_IN      (resetn),
        .CMD_WR_IN      (cmd_wr),
        .CMD_WDATA_IN   (wdata),
        .PFL_FLAG_IN    (pfl),
        .PIPE_BUSY_IN   (busy),
        .INT_ERROR_IN   (err),
        .FRINDEX_IN     (frindex),
        .LIST_BASE_IN   (base),
        .CMD_RDATA_OUT  (rdata),
        .HALTED_OUT     (halted),
        .RUN_OUT        (run),
        .FETCH_EN_OUT   (fetch_en),
        .FETCH_ADDR_OUT (faddr),
        .ENTRIES_OUT    (entries),
        .CTL_RESET_OUT  (ctl_rst),
        .PORT_COMP_OUT  (port_comp)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // called at a falling edge; returns two falling edges later so the
    // readback has landed whichever edge registers it
    task automatic wr(input logic [31:0] d);
        cmd_wr = 1'b1;
        wdata  = d;
        @(negedge clk);
        cmd_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic wait_halt(input int lim);
        int i;
        i = 0;
        while (halted !== 1'b1 && i < lim)
        begin
            @(negedge clk);
            i++;
        end
        if (halted !== 1'b1)
        begin
            n_errors++;
            $display("mismatch at %0t: no halt in time", $time);
            give_verdict();
        end
    endtask

    // own model of the list index placement, kept apart from the design
    function automatic logic [31:0] exp_addr(input logic [31:0] b,
                                             input logic [13:0] f,
                                             input logic [1:0]  s);
        logic [9:0] idx;
        case (s)
            2'h1:    idx = {1'b0, f[11:3]};
            2'h2:    idx = {2'h0, f[10:3]};
            default: idx = f[12:3];
        endcase
        return {b[31:12], idx, 2'h0};
    endfunction

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        n_errors = 0;
        comparisons = 0;
        resetn = 1'b0;
        cmd_wr = 1'b0;
        wdata = 32'h0;
        pfl = 1'b1;
        busy = 1'b0;
        err = 1'b0;
        frindex = 14'h2ABC;
        base = 32'h1234_5FFF;
        repeat (12) @(negedge clk);
        chk(32'(halted), 32'h1);
        chk(rdata, 32'h0);
        chk(32'(entries), 32'h400);
        chk(32'(run), 32'h0);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        // every valid size code, running with periodic enable
        for (int s = 0; s < 3; s++)
        begin
            frindex = frindex + 14'h0111;
            wr({27'h0, 1'b1, s[1:0], 2'h1});
            chk(rdata, {27'h0, 1'b1, s[1:0], 2'h1});
            chk(32'(entries), 32'(ent_tab[s]));
            chk(faddr, exp_addr(base, frindex, s[1:0]));
            chk(32'(fetch_en), 32'h1);
            chk(32'(run), 32'h1);
            chk(32'(halted), 32'h0);
        end
        wr(32'h0000_001D);
        chk(32'(entries), 32'h100);
        chk(32'(rdata[3:2]), 32'h2);
        wr(32'h0000_0001);
        chk(32'(fetch_en), 32'h0);
        chk(32'(run), 32'h1);
        // stop with transactions still in the pipeline
        busy = 1'b1;
        wr(32'h0000_0010);
        chk(32'(run), 32'h0);
        chk(32'(fetch_en), 32'h0);
        repeat (5) @(negedge clk);
        chk(32'(halted), 32'h0);
        busy = 1'b0;
        wait_halt(4);
        chk(32'(halted), 32'h1);
        // size field locked when not programmable
        pfl = 1'b0;
        wr(32'h0000_0004);
        chk(rdata, 32'h0);
        chk(32'(entries), 32'h400);
        pfl = 1'b1;
        // internal error stops a running controller
        wr(32'h0000_0001);
        err = 1'b1;
        @(negedge clk);
        err = 1'b0;
        @(negedge clk);
        chk(32'(run), 32'h0);
        chk(32'(rdata[0]), 32'h0);
        wait_halt(4);
        chk(32'(halted), 32'h1);
        // controller reset from halted, with fields set beforehand
        wr(32'h0000_0018);
        chk(32'(entries), 32'h100);
        cmd_wr = 1'b1;
        wdata = 32'h0000_0002;
        @(negedge clk);
        chk(32'(ctl_rst), 32'h1);
        chk(32'(port_comp), 32'h1);
        chk(32'(halted), 32'h1);
        wr(32'h0000_0000);
        chk(32'(rdata[1]), 32'h1);
        wr(32'h0000_0011);
        chk(32'(rdata[1]), 32'h1);
        chk(32'(run), 32'h0);
        k = 5;
        while (rdata[1] !== 1'b0 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        chk(32'(k >= RST_LEN && k <= RST_LEN + 3), 32'h1);
        chk(32'(ctl_rst), 32'h0);
        chk(rdata, 32'h0);
        chk(32'(entries), 32'h400);
        chk(32'(fetch_en), 32'h0);
        chk(32'(port_comp), 32'h0);
        chk(32'(halted), 32'h1);
        wr(32'h0000_0011);
        chk(32'(run), 32'h1);
        give_verdict();
    end

    // hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        $display("mismatch at %0t: run took too long", $time);
        give_verdict();
    end
endmodule
`default_nettype wire

// *** rtl/ehc_frame_fetch.sv ***
/*
 * Periodic fetch address: picks the frame list index out of the frame
 * index counter for the selected list size and places it under the
 * periodic list base. Purely combinational; the caller registers it.
 */
`timescale 1ns/1ps
`default_nettype none
module ehc_frame_fetch
    import ehc_pkg::*;
(
    input  wire logic [FRINDEX_W-1:0] frindex_in,  // frame index counter
    input  wire logic [31:0]          base_in,     // periodic list base
    input  wire logic [1:0]           fls_in,      // frame list size code
    output logic [31:0]               addr_out     // entry byte address
);
    logic [LIST_IDX_W-1:0] idx;

    assign idx      = fl_index(frindex_in, fls_in);
    // base is 4 KiB aligned; each entry is one 32-bit word
    assign addr_out = {base_in[31:LIST_BASE_LSB], idx, 2'b00};
endmodule
`default_nettype wire

// *** rtl/ehc_pkg.sv ***
/*
 * Constants and types for the command register control block: the
 * field positions of the command word, values after reset, the length
 * of the controller's own reset, and the frame list size decode.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package ehc_pkg;

    // ----------------------------------------------------------------
    // command word layout
    // ----------------------------------------------------------------
    localparam int unsigned CMD_RUN_STOP_BIT  = 0;
    localparam int unsigned CMD_SOFT_RST_BIT  = 1;
    localparam int unsigned CMD_FLS_LSB       = 2;
    localparam int unsigned CMD_FLS_MSB       = 3;
    localparam int unsigned CMD_PSE_BIT       = 4;

    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [1:0]  FLS_1024          = 2'h0;
    localparam logic [1:0]  FLS_512           = 2'h1;
    localparam logic [1:0]  FLS_256           = 2'h2;
    localparam logic [1:0]  FLS_RESERVED      = 2'h3;
    localparam logic [1:0]  FLS_RESET         = FLS_1024;
    localparam logic        PSE_RESET         = 1'b0;
    localparam logic        RUN_STOP_RESET    = 1'b0;
    localparam logic        HALTED_RESET      = 1'b1;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int unsigned FRINDEX_W         = 14;
    localparam int unsigned LIST_IDX_W        = 10;
    localparam int unsigned LIST_BASE_LSB     = 12;
    localparam int unsigned ENTRIES_W         = 11;
    localparam int unsigned SOFT_RST_CYCLES   = 16;
    localparam int unsigned SOFT_RST_CNT_W    = 8;

    typedef enum logic [1:0] {
        ST_HALTED,
        ST_RUNNING,
        ST_STOPPING
    } ehc_run_t;

    // frame list index taken from the frame index counter
    function automatic logic [LIST_IDX_W-1:0] fl_index(
        input logic [FRINDEX_W-1:0] frindex,
        input logic [1:0]           frame_list_size
    );
        case (frame_list_size)
            FLS_512: fl_index = {1'b0, frindex[11:3]};
            FLS_256: fl_index = {2'b00, frindex[10:3]};
            default: fl_index = frindex[12:3];
        endcase
    endfunction

    // number of frame list entries for a size code
    function automatic logic [ENTRIES_W-1:0] fl_entries(
        input logic [1:0] frame_list_size
    );
        case (frame_list_size)
            FLS_512: fl_entries = 11'h200;
            FLS_256: fl_entries = 11'h100;
            default: fl_entries = 11'h400;
        endcase
    endfunction

    typedef struct packed {
        logic                   busy;
        logic [SOFT_RST_CNT_W-1:0] cnt;
    } ehc_rst_state_t;

    typedef struct packed {
        logic [1:0]             sync;
        logic                   run_stop;
        logic                   periodic_sched_enable;
        logic [1:0]             frame_list_size;
        ehc_run_t               st;
        logic                   run;
        logic                   halted;
        logic [31:0]            rdata;
        logic                   fetch_en;
        logic [31:0]            fetch_addr;
        logic [ENTRIES_W-1:0]   entries;
        logic                   ctl_reset;
        logic                   port_companion;
    } ehc_top_state_t;

endpackage

// *** rtl/ehc_soft_reset_seq.sv ***
/*
 * Sequencer for the software-started controller reset: once started it
 * stays busy for a fixed number of clocks and then ends by itself.
 * Assumes a synchronous active-low reset already released cleanly.
 */
`timescale 1ns/1ps
`default_nettype none
module ehc_soft_reset_seq
    import ehc_pkg::*;
#(
    parameter int unsigned CYCLES = SOFT_RST_CYCLES
)
(
    input  wire logic clk_in,         // controller clock
    input  wire logic rst_n_in,       // synchronised reset
    input  wire logic start_in,       // one-cycle start pulse
    output logic      busy_out,       // reset in progress
    output logic      last_out        // final busy cycle
);
    ehc_rst_state_t s;
    ehc_rst_state_t next_s;

    always_comb
    begin
        next_s = s;
        if (s.busy)
        begin
            // a write of zero cannot reach here: only the count ends it
            if (s.cnt == '0)
                next_s.busy = 1'b0;
            else
                next_s.cnt = s.cnt - 1'b1;
        end
        else if (start_in)
        begin
            next_s.busy = 1'b1;
            next_s.cnt  = SOFT_RST_CNT_W'(CYCLES - 1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    assign busy_out = s.busy;
    assign last_out = s.busy && (s.cnt == '0);
endmodule
`default_nettype wire

// *** rtl/ehc_usb_command_ctrl.sv ***
/*
 * Lower fields of the controller command register: run/stop, the
 * controller's own reset, frame list size and periodic schedule enable,
 * with the halted indicator handshake.
 * Assumes software writes whole command words through a write strobe
 * and that the schedule engine reports when its pipeline has drained.
 */
// What this block does
// RULE1: periodic enable set means fetch entries via the periodic list base.
// RULE2: periodic enable clear means periodic schedule is skipped entirely.
// RULE3: frame list size bits 3..2 writable only if programmable flag set.
// RULE4: size codes 0,1,2 give 1024, 512, 256 entries; code 3 reserved.
// RULE5: size chooses which frame index counter bits form the list index.
// RULE6: writing reset bit returns pipelines, timers and state machines to init.
// RULE7: controller reset acts on root hub registers like a chip reset.
// RULE8: controller reset cuts transactions at once, drives no bus reset.
// RULE9: controller reset leaves configuration space registers alone.
// RULE10: controller reset restores all operational and port registers.
// RULE11: controller reset hands every root port back to the companion.
// RULE12: hardware clears the reset bit itself when reset completes.
// RULE13: writing zero to reset bit does not shorten a running reset.
// RULE14: software must not reset a running controller; result undefined.
// RULE15: after controller reset software must initialise again.
// RULE16: run/stop set keeps schedules executing as long as it stays set.
// RULE17: clearing run/stop finishes pipeline transactions, then halts.
// RULE18: halted indicator shows work finished and stopped state entered.
// RULE19: software checks halted reads one before setting run/stop.
// RULE20: halted resets to one, zero while running, one after stop.
// RULE21: internal error clears run/stop, same halt sequence as software.
// RULE22: without programmable flag, size writes ignored, reads back zero.
`timescale 1ns/1ps
`default_nettype none
module ehc_usb_command_ctrl
    import ehc_pkg::*;
#(
    parameter int unsigned SOFT_RESET_LEN = SOFT_RST_CYCLES
)
(
    input  wire logic                 CLK_IN,          // 25 MHz clock
    input  wire logic                 RESETN_IN,       // chip reset, low
    input  wire logic                 CMD_WR_IN,       // command write
    input  wire logic [31:0]          CMD_WDATA_IN,    // command data
    input  wire logic                 PFL_FLAG_IN,     // size programmable
    input  wire logic                 PIPE_BUSY_IN,    // pipeline not empty
    input  wire logic                 INT_ERROR_IN,    // internal error
    input  wire logic [FRINDEX_W-1:0] FRINDEX_IN,      // frame index
    input  wire logic [31:0]          LIST_BASE_IN,    // periodic base
    output logic [31:0]               CMD_RDATA_OUT,   // command readback
    output logic                      HALTED_OUT,      // halted indicator
    output logic                      RUN_OUT,         // schedules execute
    output logic                      FETCH_EN_OUT,    // periodic fetch on
    output logic [31:0]               FETCH_ADDR_OUT,  // periodic address
    output logic [ENTRIES_W-1:0]      ENTRIES_OUT,     // frame list length
    output logic                      CTL_RESET_OUT,   // internal reset
    output logic                      PORT_COMP_OUT    // ports to companion
);
    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    ehc_top_state_t s;
    ehc_top_state_t next_s;
    logic           rst_n;
    logic           rst_busy;
    logic           rst_last;
    logic           rst_start;
    logic [31:0]    fetch_addr;
    logic           wr_ok;

    assign rst_n = s.sync[1];

    // ----------------------------------------------------------------
    // initial values: chip reset lands here at once, and the release
    // window holds everything here until the second release flop is up
    // ----------------------------------------------------------------
    localparam ehc_top_state_t S_INIT = '{
        sync           : 2'b00,
        run_stop       : RUN_STOP_RESET,
        periodic_sched_enable            : PSE_RESET,
        frame_list_size            : FLS_RESET,
        st             : ST_HALTED,
        run            : 1'b0,
        halted         : HALTED_RESET,
        rdata          : 32'h0,
        fetch_en       : 1'b0,
        fetch_addr     : 32'h0,
        entries        : fl_entries(FLS_RESET),
        ctl_reset      : 1'b0,
        port_companion : 1'b0
    };

    // writes are ignored while the controller reset runs
    assign wr_ok     = CMD_WR_IN && !rst_busy; // RULE13
    // a reset request while running is accepted; its outcome is undefined
    assign rst_start = wr_ok && CMD_WDATA_IN[CMD_SOFT_RST_BIT]; // RULE14

    ehc_soft_reset_seq #(
        .CYCLES   (SOFT_RESET_LEN)
    ) u_rst_seq (
        .clk_in   (CLK_IN),
        .rst_n_in (rst_n),
        .start_in (rst_start),
        .busy_out (rst_busy),
        .last_out (rst_last)
    );

    ehc_frame_fetch u_fetch (
        .frindex_in (FRINDEX_IN),
        .base_in    (LIST_BASE_IN),
        .fls_in     (next_s.frame_list_size),
        .addr_out   (fetch_addr)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s      = s;
        next_s.sync = {s.sync[0], 1'b1};

        if (rst_start || rst_busy)
        begin
            // every operational field back to its initial value
            next_s.run_stop = RUN_STOP_RESET;          // RULE6 RULE10
            next_s.periodic_sched_enable      = PSE_RESET;               // RULE10
            next_s.frame_list_size      = FLS_RESET;               // RULE10
            next_s.st       = ST_HALTED;               // RULE6
            next_s.halted   = HALTED_RESET;            // RULE10
        end
        else
        begin
            if (wr_ok)
            begin
                next_s.run_stop = CMD_WDATA_IN[CMD_RUN_STOP_BIT]; // RULE19
                next_s.periodic_sched_enable      = CMD_WDATA_IN[CMD_PSE_BIT];
                // reserved size code is not taken; held size stays
                if (PFL_FLAG_IN &&
                    CMD_WDATA_IN[CMD_FLS_MSB:CMD_FLS_LSB] != FLS_RESERVED)
                    next_s.frame_list_size = CMD_WDATA_IN[CMD_FLS_MSB:CMD_FLS_LSB]; // RULE3 RULE4
            end
            if (!PFL_FLAG_IN)
                next_s.frame_list_size = FLS_RESET;                // RULE22
            // the error wins over a software set in the same cycle
            if (INT_ERROR_IN)
                next_s.run_stop = 1'b0;                // RULE21

            case (s.st)
                ST_HALTED:
                begin
                    if (next_s.run_stop)
                        next_s.st = ST_RUNNING;
                end
                ST_RUNNING:
                begin
                    if (!next_s.run_stop)
                        next_s.st = ST_STOPPING;       // RULE17 RULE21
                end
                ST_STOPPING:
                begin
                    // work already in the pipeline drains before halting
                    if (next_s.run_stop)
                        next_s.st = ST_RUNNING;
                    else if (!PIPE_BUSY_IN)
                        next_s.st = ST_HALTED;         // RULE17
                end
                default:
                    next_s.st = ST_HALTED;
            endcase
            next_s.halted = (next_s.st == ST_HALTED);  // RULE18 RULE20
        end

        next_s.run   = (next_s.st == ST_RUNNING);      // RULE16
        next_s.rdata = '0;
        next_s.rdata[CMD_RUN_STOP_BIT]        = next_s.run_stop;
        // reads one until the sequencer ends the reset by itself
        next_s.rdata[CMD_SOFT_RST_BIT]        = rst_busy && !rst_last; // RULE12
        next_s.rdata[CMD_FLS_MSB:CMD_FLS_LSB] = next_s.frame_list_size;
        next_s.rdata[CMD_PSE_BIT]             = next_s.periodic_sched_enable;

        next_s.fetch_en   = next_s.periodic_sched_enable && (next_s.st == ST_RUNNING); // RULE1 RULE2 RULE16
        next_s.fetch_addr = fetch_addr;                // RULE1 RULE5
        next_s.entries    = fl_entries(next_s.frame_list_size);    // RULE4
        // internal reset covers pipelines, timers, root hub and ports;
        // it never reaches configuration space, and no bus reset is sent
        next_s.ctl_reset      = rst_start || (rst_busy && !rst_last); // RULE7 RULE8 RULE9
        next_s.port_companion = rst_start || (rst_busy && !rst_last); // RULE11

        // release window: only the release flops move, so no write or
        // error seen before the second flop is up can leave a trace
        if (!rst_n)
        begin
            next_s      = S_INIT;
            next_s.sync = {s.sync[0], 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // state register: one process for the whole state, so the release
    // flops and the fields never have two drivers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            s <= S_INIT;                               // RULE20
        else
            s <= next_s;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign CMD_RDATA_OUT  = s.rdata;
    assign HALTED_OUT     = s.halted;
    assign RUN_OUT        = s.run;
    assign FETCH_EN_OUT   = s.fetch_en;
    assign FETCH_ADDR_OUT = s.fetch_addr;
    assign ENTRIES_OUT    = s.entries;
    assign CTL_RESET_OUT  = s.ctl_reset;
    assign PORT_COMP_OUT  = s.port_companion;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!rst_n);

    sequence stop_requested;
        RUN_OUT && !rst_start &&
        ((wr_ok && !CMD_WDATA_IN[CMD_RUN_STOP_BIT]) || INT_ERROR_IN);
    endsequence

    sequence pipe_drained;
        (s.st == ST_STOPPING) && !PIPE_BUSY_IN && !rst_busy && !rst_start;
    endsequence

    stop_enters_drain_a: assert property ( // RULE17
        stop_requested |=> !s.halted && !RUN_OUT)
        else $error("halted before stop drain began");

    halt_after_drain_a: assert property ( // RULE18
        pipe_drained ##0 !(wr_ok && CMD_WDATA_IN[CMD_RUN_STOP_BIT])
        |=> s.halted && !RUN_OUT)
        else $error("drained pipeline did not halt");

    no_early_halt_a: assert property ( // RULE17
        (s.st == ST_STOPPING) && PIPE_BUSY_IN && !rst_busy && !rst_start
        |=> !s.halted)
        else $error("halted while pipeline busy");

    run_clears_halt_a: assert property ( // RULE20
        $rose(s.run_stop) |-> !s.halted && RUN_OUT)
        else $error("halted while run set");

    keep_running_a: assert property ( // RULE16
        RUN_OUT |-> s.run_stop && !s.halted)
        else $error("running without run set");

    error_stops_a: assert property ( // RULE21
        INT_ERROR_IN && !rst_busy |=> !s.run_stop)
        else $error("internal error left run set");

    fls_locked_a: assert property ( // RULE22
        !PFL_FLAG_IN && !rst_busy |=> s.frame_list_size == FLS_RESET)
        else $error("size changed while not programmable");

    pse_gates_fetch_a: assert property ( // RULE2
        FETCH_EN_OUT |-> s.periodic_sched_enable && RUN_OUT)
        else $error("periodic fetch without enable");

    reset_restores_a: assert property ( // RULE10
        rst_busy |=> s.halted && !s.run_stop && !s.periodic_sched_enable && s.frame_list_size == FLS_RESET)
        else $error("controller reset left state set");

    reset_hold_a: assert property ( // RULE13
        rst_busy && !rst_last |=> rst_busy && CTL_RESET_OUT && PORT_COMP_OUT)
        else $error("controller reset cut short");

    reset_self_clear_a: assert property ( // RULE12
        $fell(rst_busy) |-> !CMD_RDATA_OUT[CMD_SOFT_RST_BIT] && !CTL_RESET_OUT)
        else $error("reset bit not cleared at end");

    fetch_addr_a: assert property ( // RULE1
        FETCH_EN_OUT |-> FETCH_ADDR_OUT[31:LIST_BASE_LSB]
                         == $past(LIST_BASE_IN[31:LIST_BASE_LSB]))
        else $error("fetch address not under list base");

    reset_entry_a: assert property ( // RULE11
        rst_start |=> CTL_RESET_OUT && PORT_COMP_OUT && s.halted
                      && !FETCH_EN_OUT && !RUN_OUT)
        else $error("controller reset did not take hold");

    size_write_a: assert property ( // RULE3
        wr_ok && !rst_start && PFL_FLAG_IN &&
        CMD_WDATA_IN[CMD_FLS_MSB:CMD_FLS_LSB] != FLS_RESERVED
        |=> s.frame_list_size == $past(CMD_WDATA_IN[CMD_FLS_MSB:CMD_FLS_LSB]))
        else $error("size write not taken");

    // a write during the controller reset must not restart anything
    busy_write_drop_a: assert property ( // RULE13
        CMD_WR_IN && rst_busy |=> !s.run_stop && !RUN_OUT)
        else $error("write taken during controller reset");
endmodule
`default_nettype wire
